// ===== src/urd_pkg.sv
package urd_pkg;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // register positions on the three address lines
  // ---------------------------------------------------------------
  localparam logic [2:0] ADR_DATA  = 3'h0;
  localparam logic [2:0] ADR_IEN   = 3'h1;
  localparam logic [2:0] ADR_FIFO  = 3'h2;
  localparam logic [2:0] ADR_LINE  = 3'h3;
  localparam logic [2:0] ADR_MODEM = 3'h4;
  localparam logic [2:0] ADR_LSTAT = 3'h5;
  localparam logic [2:0] ADR_MSTAT = 3'h6;
  localparam logic [2:0] ADR_SCR   = 3'h7;

  // ---------------------------------------------------------------
  // key values and control bit positions
  // ---------------------------------------------------------------
  localparam logic [7:0] BANK_KEY  = 8'hBF;
  localparam logic [7:0] DIV_ZERO  = 8'h00;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] RD_NONE   = 8'h00;
  localparam int         DLAB_BIT  = 7;
  localparam int         ENH_BIT   = 4;
  localparam int         BANK_BIT  = 6;

  // ---------------------------------------------------------------
  // fifo control fields
  // ---------------------------------------------------------------
  localparam int         FCT_EN    = 0;
  localparam int         FCT_RXRST = 1;
  localparam int         FCT_TXRST = 2;
  localparam int         FCT_WAKE  = 3;
  localparam int         FCT_TXTRG = 4;
  localparam int         FCT_RXTRG = 6;
  localparam int         TRIG_W    = 2;

  // ---------------------------------------------------------------
  // interrupt enable bits and enhanced masks
  // ---------------------------------------------------------------
  localparam int         IE_RXDATA = 0;
  localparam int         IE_TXEMPT = 1;
  localparam int         IE_LSTAT  = 2;
  localparam int         IE_MSTAT  = 3;
  localparam int         IE_SLEEP  = 4;
  localparam int         IE_FSTOP  = 5;
  localparam int         IE_RTS    = 6;
  localparam int         IE_CTS    = 7;
  localparam logic [7:0] IE_BASE_M = 8'h0F;
  localparam logic [7:0] IS_BASE_M = 8'hCF;

  // ---------------------------------------------------------------
  // identity codes (values arbitrary) and idle level of the control pins
  // ---------------------------------------------------------------
  localparam logic [7:0] REV_DEF   = 8'hA5;
  localparam logic [7:0] ID_DEF    = 8'h5A;
  localparam logic [2:0] CTL_IDLE  = 3'h7;
endpackage : urd_pkg

// ===== src/urd_top.sv

module urd_sync #(
  parameter int            W    = 1,
  parameter logic [W-1:0]  INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // a bit counts only once two later stages agree
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      dout <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (agree & s3_q) | (~agree & dout);
    end
  end
endmodule : urd_sync

module urd_top
#(
  parameter logic [7:0] REV_CODE = urd_pkg::REV_DEF,
  parameter logic [7:0] ID_CODE  = urd_pkg::ID_DEF
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // host bus pins
  input  wire logic       cs_b,
  input  wire logic       rd_b,
  input  wire logic       wr_b,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  // status from the uart core
  input  wire logic [7:0] rx_data,
  input  wire logic [7:0] int_status,
  input  wire logic [7:0] line_status,
  input  wire logic [7:0] modem_status,
  input  wire logic [7:0] fifo_level,
  // data movement strobes
  output logic [7:0]      tx_data,
  output logic            tx_push,
  output logic            rx_pop,
  // control towards the uart core
  output logic [7:0]      divisor_low,
  output logic [7:0]      divisor_high,
  output logic [7:0]      divisor_fraction,
  output logic [7:0]      interrupt_enable,
  output logic [7:0]      line_control,
  output logic [7:0]      modem_control,
  output logic            fifo_enable,
  output logic            rx_fifo_reset,
  output logic            tx_fifo_reset,
  output logic            wake_int_en,
  output logic [1:0]      tx_trigger,
  output logic [1:0]      rx_trigger,
  output logic [7:0]      ext_control,
  output logic [7:0]      enhanced_mode_select,
  output logic [7:0]      feature_control,
  output logic [7:0]      enhanced_function,
  output logic [7:0]      scratch_pad,
  output logic [7:0]      xon_one,
  output logic [7:0]      xon_two,
  output logic [7:0]      xoff_one,
  output logic [7:0]      xoff_two
);
  timeunit 1ns;
  timeprecision 100ps;
  import urd_pkg::*;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_m_q;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  logic [2:0] ctl_s;
  logic [2:0] adr_s;
  logic [7:0] dat_s;
  urd_sync #(.W(3), .INIT(CTL_IDLE)) u_ctl (
    .clk(clk), .rst_n(rst_n), .din({cs_b, rd_b, wr_b}), .dout(ctl_s));
  urd_sync #(.W(3), .INIT(ADR_DATA)) u_adr (
    .clk(clk), .rst_n(rst_n), .din(addr), .dout(adr_s));
  urd_sync #(.W(8), .INIT(REG_RST)) u_dat (
    .clk(clk), .rst_n(rst_n), .din(data_in), .dout(dat_s));

  // ---------------------------------------------------------------
  // access strobes
  // ---------------------------------------------------------------
  // both strobes act at the trailing edge, so a read never changes
  // the data the host is still sampling
  wire rd_act = ~ctl_s[2] & ~ctl_s[1];
  wire wr_act = ~ctl_s[2] & ~ctl_s[0];
  logic       rd_act_q;
  logic       wr_act_q;
  logic [2:0] ra_q;
  logic [2:0] wa_q;
  logic [7:0] wd_q;
  wire  rd_go = rd_act_q & ~rd_act;
  wire  wr_go = wr_act_q & ~wr_act;

  // ---------------------------------------------------------------
  // bank decode
  // ---------------------------------------------------------------
  wire bank    = line_control == BANK_KEY;
  wire dlab    = line_control[DLAB_BIT];
  wire div_acc = dlab & ~bank;
  wire enh     = enhanced_function[ENH_BIT];
  wire div_nul = (divisor_low == DIV_ZERO) & (divisor_high == DIV_ZERO);
  wire sel_frac = div_acc & enh;
  wire sel_stat = (~dlab & enh) | (~bank & ~enh);
  wire lvl_bank = feature_control[BANK_BIT];

  wire w0 = wr_go & (wa_q == ADR_DATA);
  wire w1 = wr_go & (wa_q == ADR_IEN);
  wire w2 = wr_go & (wa_q == ADR_FIFO);
  wire w3 = wr_go & (wa_q == ADR_LINE);
  wire w4 = wr_go & (wa_q == ADR_MODEM);
  wire w5 = wr_go & (wa_q == ADR_LSTAT);
  wire w6 = wr_go & (wa_q == ADR_MSTAT);
  wire w7 = wr_go & (wa_q == ADR_SCR);

  wire wr_tx   = w0 & ~dlab;
  wire wr_fctl = w2 & ~bank & ~sel_frac & sel_stat;
  wire wr_ext  = w6 & ~bank & enh;
  wire [7:0] ie_mask = enh ? 8'hFF : IE_BASE_M;

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  wire [7:0] is_rd = int_status & (enh ? 8'hFF : IS_BASE_M);
  wire [7:0] rd0 = bank ? fifo_level : div_acc ? (div_nul ? REV_CODE : divisor_low)
                 : rx_data;
  wire [7:0] rd1 = bank ? feature_control : div_acc ? (div_nul ? ID_CODE : divisor_high)
                 : interrupt_enable;
  wire [7:0] rd2 = bank ? enhanced_function : sel_frac ? divisor_fraction
                 : sel_stat ? is_rd : RD_NONE;
  wire [7:0] rd4 = bank ? xon_one : modem_control;
  wire [7:0] rd5 = bank ? xon_two : line_status;
  wire [7:0] rd6 = bank ? xoff_one : modem_status;
  wire [7:0] rd7 = bank ? xoff_two : lvl_bank ? fifo_level : scratch_pad;
  logic [7:0] rd_d;
  always_comb begin
    unique case (ra_q)
      ADR_DATA:  rd_d = rd0;
      ADR_IEN:   rd_d = rd1;
      ADR_FIFO:  rd_d = rd2;
      ADR_LINE:  rd_d = line_control;
      ADR_MODEM: rd_d = rd4;
      ADR_LSTAT: rd_d = rd5;
      ADR_MSTAT: rd_d = rd6;
      ADR_SCR:   rd_d = rd7;
    endcase
  end
  assign data_oe = rd_act;

  // ---------------------------------------------------------------
  // bus capture and strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_q      <= 1'b0;
      wr_act_q      <= 1'b0;
      ra_q          <= ADR_DATA;
      wa_q          <= ADR_DATA;
      wd_q          <= REG_RST;
      data_out      <= REG_RST;
      tx_data       <= REG_RST;
      tx_push       <= 1'b0;
      rx_pop        <= 1'b0;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end else begin
      rd_act_q      <= rd_act;
      wr_act_q      <= wr_act;
      ra_q          <= adr_s;
      if (wr_act) begin
        wa_q <= adr_s;
        wd_q <= dat_s;
      end
      data_out      <= rd_d;
      // popping only on a real receive read, never on a bank read
      rx_pop        <= rd_go & (ra_q == ADR_DATA) & ~dlab;
      tx_push       <= wr_tx;
      if (wr_tx) tx_data <= wd_q;
      rx_fifo_reset <= wr_fctl & wd_q[FCT_RXRST];
      tx_fifo_reset <= wr_fctl & wd_q[FCT_TXRST];
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_low          <= REG_RST;
      divisor_high         <= REG_RST;
      divisor_fraction     <= REG_RST;
      interrupt_enable     <= REG_RST;
      line_control         <= REG_RST;
      modem_control        <= REG_RST;
      fifo_enable          <= 1'b0;
      wake_int_en          <= 1'b0;
      tx_trigger           <= 2'h0;
      rx_trigger           <= 2'h0;
      ext_control          <= REG_RST;
      enhanced_mode_select <= REG_RST;
      feature_control      <= REG_RST;
      enhanced_function    <= REG_RST;
      scratch_pad          <= REG_RST;
      xon_one              <= REG_RST;
      xon_two              <= REG_RST;
      xoff_one             <= REG_RST;
      xoff_two             <= REG_RST;
    end else begin
      if (w0 & div_acc) divisor_low <= wd_q;
      if (w1 & div_acc) divisor_high <= wd_q;
      if (w2 & sel_frac & ~bank) divisor_fraction <= wd_q;
      // enhanced enable bits drop as soon as enhanced mode is left
      if (w1 & ~dlab) interrupt_enable <= wd_q & ie_mask;
      else interrupt_enable <= interrupt_enable & ie_mask;
      if (w3) line_control <= wd_q;
      if (w4 & ~bank) modem_control <= wd_q;
      if (wr_fctl) begin
        fifo_enable <= wd_q[FCT_EN];
        wake_int_en <= wd_q[FCT_WAKE];
        tx_trigger  <= wd_q[FCT_TXTRG +: TRIG_W];
        rx_trigger  <= wd_q[FCT_RXTRG +: TRIG_W];
      end
      if (wr_ext) ext_control <= wd_q;
      if (w7 & ~bank & lvl_bank) enhanced_mode_select <= wd_q;
      if (w7 & ~bank & ~lvl_bank) scratch_pad <= wd_q;
      if (w1 & bank) feature_control <= wd_q;
      if (w2 & bank) enhanced_function <= wd_q;
      if (w4 & bank) xon_one <= wd_q;
      if (w5 & bank) xon_two <= wd_q;
      if (w6 & bank) xoff_one <= wd_q;
      if (w7 & bank) xoff_two <= wd_q;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_div_low;
    w0 & div_acc |=> divisor_low == $past(wd_q);
  endproperty
  a_div_low: assert property (p_div_low) else $error("divisor low not written");

  property p_frac_hold;
    w2 & div_acc & ~enh |=> $stable(divisor_fraction) && !rx_fifo_reset == !$past(wd_q[1]);
  endproperty
  a_frac_hold: assert property (p_frac_hold) else $error("fraction written without enh");

  property p_rev_read;
    (ra_q == ADR_DATA) & div_acc & div_nul |=> data_out == REV_CODE;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision code not returned");

  property p_tx_push;
    w0 & ~dlab |=> tx_push && tx_data == $past(wd_q) ##1 !tx_push;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("transmit push wrong");

  property p_fcr_trig;
    w2 & ~bank & ~dlab |=> rx_trigger == $past(wd_q[7:6]) && fifo_enable == $past(wd_q[0]);
  endproperty
  a_fcr_trig: assert property (p_fcr_trig) else $error("fifo control not decoded");

  property p_enh_zero;
    !enh && $past(!enh) |-> interrupt_enable[7:4] == 4'h0;
  endproperty
  a_enh_zero: assert property (p_enh_zero) else $error("enhanced enable bits live");

  property p_line_ctl;
    w3 |=> line_control == $past(wd_q);
  endproperty
  a_line_ctl: assert property (p_line_ctl) else $error("line control not written");

  property p_bank_rd;
    bank & (ra_q == ADR_SCR) |=> data_out == $past(xoff_two);
  endproperty
  a_bank_rd: assert property (p_bank_rd) else $error("bank read wrong");

  property p_lstat_ro;
    w5 & ~bank |=> $stable(xon_two) && $stable(line_control) && $stable(modem_control);
  endproperty
  a_lstat_ro: assert property (p_lstat_ro) else $error("read-only write took effect");

  property p_rx_pop;
    rd_go & (ra_q == ADR_DATA) & ~dlab |=> rx_pop ##1 !rx_pop;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive pop missing");

  c_tx:   cover property (wr_tx);
  c_bank: cover property (w2 & bank);
  c_rev:  cover property ((ra_q == ADR_DATA) & div_acc & div_nul & rd_go);
  c_msel: cover property (w7 & ~bank & lvl_bank);
endmodule : urd_top

// ===== verif/urd_host_model.sv
module urd_host_model (
  // clock
  input  wire logic       clk,
  // host bus pins
  output logic            cs_b,
  output logic            rd_b,
  output logic            wr_b,
  output logic      [2:0] addr,
  output logic      [7:0] wdata,
  // read return
  input  wire logic [7:0] bus_rdata,
  input  wire logic       bus_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial begin
    cs_b  = 1'b1;
    rd_b  = 1'b1;
    wr_b  = 1'b1;
    addr  = 3'h0;
    wdata = 8'h00;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // data held past the strobe edge, since commit uses the last active value
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    cs_b  = 1'b0;
    wr_b  = 1'b0;
    idle(8);
    cs_b  = 1'b1;
    wr_b  = 1'b1;
    idle(8);
    // released bus: show the inverse rather than a stale copy
    wdata = ~d;
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    addr = a;
    cs_b = 1'b0;
    rd_b = 1'b0;
    idle(8);
    d    = bus_rdata;
    oe   = bus_oe;
    cs_b = 1'b1;
    rd_b = 1'b1;
    idle(8);
  endtask : bus_rd
endmodule : urd_host_model

// ===== verif/testbench.sv
`define CHK(g, e) chk(8'(g), 8'(e));

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import urd_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [7:0] REV_EXP = 8'h3C;  // arbitrary
  localparam logic [7:0] ID_EXP  = 8'hC3;  // arbitrary
  logic       clk, rst_b, cs_b, rd_b, wr_b, data_oe, oe_v;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, rd_v, rx_data, int_status, line_status, modem_status;
  logic [7:0] fifo_level, tx_data, divisor_low, divisor_high, divisor_fraction;
  logic [7:0] interrupt_enable, line_control, modem_control, ext_control;
  logic [7:0] enhanced_mode_select, scratch_pad;
  logic       tx_push, rx_pop, fifo_enable, rx_fifo_reset, tx_fifo_reset, wake_int_en;
  logic [1:0] tx_trigger, rx_trigger;
  int         error_cnt, cmp_count, push_cnt, pop_cnt, rxr_cnt, txr_cnt;
  logic [7:0] bank_v [8];

  urd_host_model i_host (.clk(clk), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr),
    .wdata(data_in), .bus_rdata(data_out), .bus_oe(data_oe));

  urd_top #(.REV_CODE(REV_EXP), .ID_CODE(ID_EXP)) i_dut (.clk(clk), .rst_b(rst_b),
    .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rx_data(rx_data), .int_status(int_status),
    .line_status(line_status), .modem_status(modem_status), .fifo_level(fifo_level),
    .tx_data(tx_data), .tx_push(tx_push), .rx_pop(rx_pop), .divisor_low(divisor_low),
    .divisor_high(divisor_high), .divisor_fraction(divisor_fraction),
    .interrupt_enable(interrupt_enable), .line_control(line_control),
    .modem_control(modem_control), .fifo_enable(fifo_enable),
    .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset),
    .wake_int_en(wake_int_en), .tx_trigger(tx_trigger), .rx_trigger(rx_trigger),
    .ext_control(ext_control), .enhanced_mode_select(enhanced_mode_select),
    .feature_control(), .enhanced_function(), .scratch_pad(scratch_pad), .xon_one(),
    .xon_two(), .xoff_one(), .xoff_two());

  always #5 clk = ~clk;

  // pulses are one cycle wide, so count them rather than sample once
  always @(posedge clk) begin
    if (tx_push === 1'b1) push_cnt <= push_cnt + 1;
    if (rx_pop === 1'b1) pop_cnt <= pop_cnt + 1;
    if (rx_fifo_reset === 1'b1) rxr_cnt <= rxr_cnt + 1;
    if (tx_fifo_reset === 1'b1) txr_cnt <= txr_cnt + 1;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    i_host.bus_rd(a, rd_v, oe_v);
    chk(8'(oe_v), 8'h01);
    chk(rd_v, e);
  endtask : rd_chk

  task automatic report_and_stop();
    $display("errors %0d, compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    #300us;
    error_cnt++;
    $display("MISMATCH t=%0t run did not finish", $time);
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_b = 1'b0; error_cnt = 0; cmp_count = 0;
    push_cnt = 0; pop_cnt = 0; rxr_cnt = 0; txr_cnt = 0;
    rx_data = 8'h3C; int_status = 8'hF1; line_status = 8'h61;
    modem_status = 8'hB2; fifo_level = 8'h07;
    bank_v = '{8'h00, 8'h40, 8'h10, 8'hBF, 8'h11, 8'h22, 8'h33, 8'h44};
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(line_control, 8'h00)
    // zero divisor shows the identity pair
    i_host.bus_wr(3'h3, 8'h80);
    rd_chk(3'h0, REV_EXP);
    rd_chk(3'h1, ID_EXP);
    // address 2 under divisor access without enhanced enable
    i_host.bus_wr(3'h2, 8'h01);
    `CHK(divisor_fraction, 8'h00)
    `CHK(fifo_enable, 1'b1)
    rd_chk(3'h2, 8'hC1);
    i_host.bus_wr(3'h0, 8'h12);
    `CHK(divisor_low, 8'h12)
    rd_chk(3'h0, 8'h12);
    rd_chk(3'h1, 8'h00);
    // data port and plain bank
    i_host.bus_wr(3'h3, 8'h03);
    rd_chk(3'h3, 8'h03);
    i_host.bus_wr(3'h0, 8'hA7);
    `CHK(tx_data, 8'hA7)
    `CHK(push_cnt, 1)
    rd_chk(3'h0, 8'h3C);
    `CHK(pop_cnt, 1)
    `CHK(divisor_low, 8'h12)
    i_host.bus_wr(3'h1, 8'hFF);
    rd_chk(3'h1, 8'h0F);
    `CHK(interrupt_enable, 8'h0F)
    rd_chk(3'h2, int_status & IS_BASE_M);
    i_host.bus_wr(3'h2, 8'hEF);
    `CHK({fifo_enable, wake_int_en, tx_trigger, rx_trigger}, 8'h3B)
    `CHK({rxr_cnt[3:0], txr_cnt[3:0]}, 8'h11)
    rd_chk(3'h5, 8'h61);
    i_host.bus_wr(3'h5, 8'h55);
    rd_chk(3'h5, 8'h61);
    i_host.bus_wr(3'h4, 8'h0A);
    rd_chk(3'h4, 8'h0A);
    rd_chk(3'h6, 8'hB2);
    i_host.bus_wr(3'h6, 8'h90);
    `CHK(ext_control, 8'h00)
    i_host.bus_wr(3'h7, 8'h5E);
    rd_chk(3'h7, 8'h5E);
    // keyed bank
    i_host.bus_wr(3'h3, 8'hBF);
    rd_chk(3'h0, 8'h07);
    i_host.bus_wr(3'h0, 8'h99);
    `CHK(divisor_low, 8'h12)
    for (int a = 1; a < 8; a++) begin
      i_host.bus_wr(3'(a), bank_v[a]);
    end
    for (int a = 1; a < 8; a++) begin
      rd_chk(3'(a), bank_v[a]);
    end
    `CHK(modem_control, 8'h0A)
    // enhanced features on
    i_host.bus_wr(3'h3, 8'h03);
    i_host.bus_wr(3'h1, 8'hFF);
    rd_chk(3'h1, 8'hFF);
    rd_chk(3'h2, 8'hF1);
    i_host.bus_wr(3'h6, 8'h90);
    `CHK(ext_control, 8'h90)
    rd_chk(3'h6, 8'hB2);
    rd_chk(3'h7, 8'h07);
    i_host.bus_wr(3'h7, 8'h0C);
    `CHK(enhanced_mode_select, 8'h0C)
    `CHK(scratch_pad, 8'h5E)
    i_host.bus_wr(3'h3, 8'h80);
    i_host.bus_wr(3'h2, 8'h5C);
    `CHK(divisor_fraction, 8'h5C)
    rd_chk(3'h2, 8'h5C);
    rd_chk(3'h1, 8'h00);
    report_and_stop();
  end
endmodule : testbench
